// file: src/ifi_pkg.sv
/*
 * Constants shared by the interlock fault indicator: fault codes,
 * flash timing and long supervision times.
 * Assumes a 20 MHz core clock and a 1 ms time base derived from it.
 */
package ifi_pkg;
    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    // ------------------------------------------------------------
    // supervision times
    // ------------------------------------------------------------
    localparam int unsigned WARN_MIN = 30;
    localparam int unsigned TAMPER_MIN = 10;
    localparam int unsigned WARN_MS = WARN_MIN * 60 * MS_PER_S;
    localparam int unsigned TAMPER_MS = TAMPER_MIN * 60 * MS_PER_S;
    // control toggle limit, in tenths of a hertz
    localparam int unsigned CTRL_MAX_DHZ = 3;
    // shortest legal gap between edges, rounded up
    localparam int unsigned CTRL_MIN_GAP_MS =
        (10 * MS_PER_S + 2 * CTRL_MAX_DHZ - 1) / (2 * CTRL_MAX_DHZ);

    // ------------------------------------------------------------
    // flash timing, ms
    // ------------------------------------------------------------
    localparam int unsigned FLASH_ON_MS = 200;
    localparam int unsigned FLASH_OFF_MS = 300;
    localparam int unsigned FLASH_GAP_MS = 1500;
    localparam int unsigned BLINK_FRAME_MS = 1000;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned FAST_HALF_MS = 125;
    localparam int unsigned YEL_2HZ_HALF_MS = 250;
    localparam int unsigned POWER_HALF_MS = 500;

    // ------------------------------------------------------------
    // red flash codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_OUT_A = 4'h1;
    localparam logic [3:0] CODE_OUT_B = 4'h2;
    localparam logic [3:0] CODE_CROSS = 4'h3;
    localparam logic [3:0] CODE_TEMP = 4'h4;
    localparam logic [3:0] CODE_ACT = 4'h5;
    localparam logic [3:0] CODE_CTRL = 4'h6;
    localparam logic [3:0] CODE_DETECT = 4'h7;
    localparam logic [3:0] CODE_BOLT = 4'h8;
    localparam logic [3:0] CODE_SUPPLY = 4'h9;
    localparam logic [3:0] CODE_STEADY = 4'hF;
endpackage

// file: src/ifi_flash_gen.sv
/*
 * Red LED flash-code generator: n pulses then a pause, or steady on.
 * Assumes a one-cycle 1 ms tick from the parent.
 */
`timescale 1ns/1ps
module ifi_flash_gen (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // time base and code
    input wire logic tick_in,
    input wire logic [3:0] code_in,
    // led
    output logic led_out
);
    typedef enum logic [1:0] {
        IFI_FL_IDLE = 2'b00,
        IFI_FL_ON = 2'b01,
        IFI_FL_OFF = 2'b10,
        IFI_FL_GAP = 2'b11
    } ifi_fl_e;

    typedef struct packed {
        ifi_fl_e st;
        logic [15:0] ms;
        logic [3:0] left;
        logic led;
    } ifi_fl_s;

    ifi_fl_s r;
    ifi_fl_s next_r;

    always_comb begin
        next_r = r;
        if (code_in == ifi_pkg::CODE_STEADY) begin
            next_r.st = IFI_FL_IDLE;
            next_r.led = 1'b1;
        end else if (tick_in) begin
            next_r.ms = r.ms + 16'h0001;
            case (r.st)
                IFI_FL_IDLE: begin
                    next_r.led = 1'b0;
                    if (code_in != ifi_pkg::CODE_NONE) begin
                        next_r.st = IFI_FL_ON;
                        next_r.left = code_in;
                        next_r.ms = 16'h0000;
                        next_r.led = 1'b1;
                    end
                end
                IFI_FL_ON: begin
                    if (32'(r.ms) + 1 >= ifi_pkg::FLASH_ON_MS) begin
                        next_r.led = 1'b0;
                        next_r.ms = 16'h0000;
                        next_r.left = r.left - 4'h1;
                        next_r.st = (r.left == 4'h1) ? IFI_FL_GAP
                                                     : IFI_FL_OFF;
                    end
                end
                IFI_FL_OFF: begin
                    if (32'(r.ms) + 1 >= ifi_pkg::FLASH_OFF_MS) begin
                        next_r.led = 1'b1;
                        next_r.ms = 16'h0000;
                        next_r.st = IFI_FL_ON;
                    end
                end
                IFI_FL_GAP: begin
                    // a code change takes effect at the next cycle start
                    if (32'(r.ms) + 1 >= ifi_pkg::FLASH_GAP_MS) begin
                        next_r.ms = 16'h0000;
                        next_r.st = IFI_FL_IDLE;
                    end
                end
                default: next_r.st = IFI_FL_IDLE;
            endcase
        end
        if (code_in == ifi_pkg::CODE_NONE) begin
            next_r.st = IFI_FL_IDLE;
            next_r.led = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign led_out = r.led;
endmodule

// file: src/ifi_rate_mon.sv
/*
 * Toggle-rate monitor for the two locking control inputs.
 * Assumes inputs synchronous to the clock and a 1 ms tick.
 */
`timescale 1ns/1ps
module ifi_rate_mon #(
    parameter int unsigned MIN_GAP_MS = ifi_pkg::CTRL_MIN_GAP_MS
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // inputs
    input wire logic tick_in,
    input wire logic lock_ctrl_in_a,
    input wire logic lock_ctrl_in_b,
    // result
    output logic too_fast_out
);
    typedef struct packed {
        logic [1:0] prev;
        logic [15:0] gap;
        logic seen;
        logic err;
    } ifi_rm_s;

    ifi_rm_s r;
    ifi_rm_s next_r;
    logic edge_seen;

    always_comb begin
        next_r = r;
        edge_seen = ({lock_ctrl_in_a, lock_ctrl_in_b} != r.prev);
        next_r.prev = {lock_ctrl_in_a, lock_ctrl_in_b};
        if (tick_in && 32'(r.gap) < MIN_GAP_MS) begin
            next_r.gap = r.gap + 16'h0001;
        end
        if (edge_seen) begin
            // two edges closer than the limit mean > 0.3 Hz toggling
            if (r.seen && 32'(r.gap) < MIN_GAP_MS) begin
                next_r.err = 1'b1;
            end
            next_r.gap = 16'h0000;
            next_r.seen = 1'b1;
        end else if (32'(r.gap) >= MIN_GAP_MS) begin
            next_r.err = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign too_fast_out = r.err;
endmodule

// file: src/ifi_top.sv
/*
 * Interlock fault indicator: classifies fault conditions into LED flash
 * codes, runs the 30 minute warning shutdown, and drives LEDs and
 * outputs during teach-in and the tamper-protection time.
 * Assumes fault detectors deliver synchronous levels and that the
 * tamper pending flag is kept in non-volatile storage outside.
 */
`timescale 1ns/1ps
module ifi_top #(
    parameter int unsigned MS_CYCLES = ifi_pkg::MS_CYCLES,
    parameter int unsigned WARN_MS = ifi_pkg::WARN_MS,
    parameter int unsigned TAMPER_MS = ifi_pkg::TAMPER_MS
) (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // warning-class fault detectors
    input wire logic fault_out_a_in,
    input wire logic fault_out_b_in,
    input wire logic fault_cross_in,
    input wire logic fault_temp_in,
    // immediate-class fault detectors
    input wire logic fault_actuator_in,
    input wire logic fault_detect_in,
    input wire logic fault_bolt_in,
    input wire logic fault_supply_in,
    input wire logic fault_internal_in,
    // indicate-only fault detector
    input wire logic fault_ctrl_in,
    // locking control inputs
    input wire logic lock_ctrl_in_a,
    input wire logic lock_ctrl_in_b,
    // operation and teach-in
    input wire logic enable_req_in,
    input wire logic reteachable_variant_in,
    input wire logic teach_started_in,
    input wire logic teach_ready_in,
    input wire logic teach_done_in,
    input wire logic tamper_pending_in,
    // safety and diagnostic outputs
    output logic safety_out_a_out,
    output logic safety_out_b_out,
    output logic diag_out_a_out,
    output logic diag_out_b_out,
    // leds
    output logic led_power_out,
    output logic led_fault_out,
    output logic led_status_out,
    // status
    output logic warn_active_out,
    output logic tamper_active_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IFI_MODE_RUN = 2'b00,
        IFI_MODE_TEACH = 2'b01,
        IFI_MODE_TAMPER = 2'b10
    } ifi_mode_e;

    typedef struct packed {
        logic [15:0] div;
        logic tick;
        logic [15:0] blink;
        logic [31:0] warn_ms;
        logic warn_expired;
        logic [31:0] tamper_ms;
        logic started;
        ifi_mode_e mode;
        logic [3:0] code;
        logic safe_a;
        logic safe_b;
        logic diag_a;
        logic diag_b;
        logic led_pwr;
        logic led_sts;
    } ifi_top_s;

    ifi_top_s r;
    ifi_top_s next_r;

    logic ctrl_too_fast;
    logic red_flash;
    logic warn_cond;
    logic cut_now;
    logic [3:0] code_sel;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // square wave from the shared 1 s frame
    function automatic logic blink_on(input logic [15:0] ms,
                                      input int unsigned half);
        blink_on = ((32'(ms) % (2 * half)) < half);
    endfunction

    // highest-severity code wins the red LED
    function automatic logic [3:0] fault_code(input logic [9:0] f);
        logic [3:0] c;
        c = ifi_pkg::CODE_NONE;
        if (f[0]) begin
            c = ifi_pkg::CODE_STEADY;
        end else if (f[1]) begin
            c = ifi_pkg::CODE_SUPPLY;
        end else if (f[2]) begin
            c = ifi_pkg::CODE_ACT;
        end else if (f[3]) begin
            c = ifi_pkg::CODE_DETECT;
        end else if (f[4]) begin
            c = ifi_pkg::CODE_BOLT;
        end else if (f[5]) begin
            c = ifi_pkg::CODE_CTRL;
        end else if (f[6] || (f[8] && f[9])) begin
            c = ifi_pkg::CODE_CROSS;
        end else if (f[7]) begin
            c = ifi_pkg::CODE_TEMP;
        end else if (f[9]) begin
            c = ifi_pkg::CODE_OUT_B;
        end else if (f[8]) begin
            c = ifi_pkg::CODE_OUT_A;
        end
        fault_code = c;
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    ifi_rate_mon u_rate (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tick_in(r.tick),
        .lock_ctrl_in_a(lock_ctrl_in_a),
        .lock_ctrl_in_b(lock_ctrl_in_b),
        .too_fast_out(ctrl_too_fast)
    );

    ifi_flash_gen u_flash (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tick_in(r.tick),
        .code_in(r.code),
        .led_out(red_flash)
    );

    // ------------------------------------------------------------
    // fault classes
    // ------------------------------------------------------------
    assign warn_cond = fault_out_a_in | fault_out_b_in | fault_cross_in |
                       fault_temp_in;
    assign cut_now = fault_actuator_in | fault_detect_in | fault_bolt_in |
                     fault_supply_in | fault_internal_in |
                     ctrl_too_fast;
    assign code_sel = fault_code({fault_out_b_in, fault_out_a_in,
                                  fault_temp_in, fault_cross_in,
                                  fault_ctrl_in, fault_bolt_in,
                                  fault_detect_in, fault_actuator_in,
                                  fault_supply_in, fault_internal_in});

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        next_r.code = code_sel;
        // 1 ms time base
        if (32'(r.div) + 1 >= MS_CYCLES) begin
            next_r.div = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + 16'h0001;
        end
        if (r.tick) begin
            next_r.blink = (32'(r.blink) + 1 >= ifi_pkg::BLINK_FRAME_MS)
                ? 16'h0000 : r.blink + 16'h0001;
        end

        // warning timer; cleared as soon as no warning cause remains
        if (!warn_cond) begin
            next_r.warn_ms = 32'h0000_0000;
            next_r.warn_expired = 1'b0;
        end else if (r.tick && !r.warn_expired) begin
            if (r.warn_ms + 32'h0000_0001 >= WARN_MS) begin
                next_r.warn_expired = 1'b1;
            end
            next_r.warn_ms = r.warn_ms + 32'h0000_0001;
        end

        // tamper time: loaded on teach done, or reloaded after reset
        if (!r.started) begin
            next_r.started = 1'b1;
            if (tamper_pending_in && reteachable_variant_in) begin
                next_r.tamper_ms = 32'(TAMPER_MS);
            end
        end else if (teach_done_in && reteachable_variant_in) begin
            next_r.tamper_ms = 32'(TAMPER_MS);
        end else if (r.tick && r.tamper_ms != 32'h0000_0000) begin
            next_r.tamper_ms = r.tamper_ms - 32'h0000_0001;
        end

        // operating mode
        case (r.mode)
            IFI_MODE_RUN, IFI_MODE_TAMPER: begin
                if (teach_started_in) begin
                    next_r.mode = IFI_MODE_TEACH;
                end else if (next_r.tamper_ms != 32'h0000_0000) begin
                    next_r.mode = IFI_MODE_TAMPER;
                end else begin
                    next_r.mode = IFI_MODE_RUN;
                end
            end
            IFI_MODE_TEACH: begin
                if (!teach_started_in && !teach_ready_in) begin
                    next_r.mode = (next_r.tamper_ms != 32'h0000_0000)
                        ? IFI_MODE_TAMPER : IFI_MODE_RUN;
                end
            end
            default: next_r.mode = IFI_MODE_RUN;
        endcase

        // outputs and leds
        case (next_r.mode)
            IFI_MODE_TEACH: begin
                next_r.safe_a = 1'b0;
                next_r.safe_b = 1'b0;
                next_r.diag_a = 1'b0;
                next_r.diag_b = 1'b0;
                next_r.led_pwr = 1'b0;
                next_r.led_sts = teach_ready_in
                    ? blink_on(next_r.blink, ifi_pkg::FAST_HALF_MS)
                    : blink_on(next_r.blink, ifi_pkg::SLOW_HALF_MS);
            end
            IFI_MODE_TAMPER: begin
                next_r.safe_a = 1'b0;
                next_r.safe_b = 1'b0;
                next_r.diag_a = 1'b0;
                next_r.diag_b = 1'b1;
                next_r.led_pwr =
                    blink_on(next_r.blink, ifi_pkg::POWER_HALF_MS);
                next_r.led_sts = 1'b0;
            end
            default: begin
                // fault_ctrl_in alone never reaches the cut terms
                next_r.safe_a = enable_req_in && !cut_now &&
                                !next_r.warn_expired;
                next_r.safe_b = next_r.safe_a;
                next_r.diag_a = next_r.safe_a;
                // drops on any warning so a process can stop in time
                next_r.diag_b = enable_req_in && !cut_now && !warn_cond;
                next_r.led_pwr = 1'b1;
                if (ctrl_too_fast) begin
                    next_r.led_sts =
                        blink_on(next_r.blink, ifi_pkg::YEL_2HZ_HALF_MS);
                end else begin
                    next_r.led_sts = next_r.safe_a;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign safety_out_a_out = r.safe_a;
    assign safety_out_b_out = r.safe_b;
    assign diag_out_a_out = r.diag_a;
    assign diag_out_b_out = r.diag_b;
    assign led_power_out = r.led_pwr;
    // red is steady in teach-in and dark in tamper time
    assign led_fault_out = (r.mode == IFI_MODE_TEACH) ? 1'b1 :
                           (r.mode == IFI_MODE_TAMPER) ? 1'b0 :
                           red_flash;
    assign led_status_out = r.led_sts;
    assign warn_active_out = (r.warn_ms != 32'h0000_0000) ||
                             r.warn_expired;
    assign tamper_active_out = (r.tamper_ms != 32'h0000_0000);
endmodule

// file: bench/ifi_top_assertions.sv
/* Checker for ifi_top port behaviour.
   Assumes the same parameters as the bound instance. */
`timescale 1ns/1ps
module ifi_top_chk #(
    parameter int unsigned MS_CYCLES = 4,
    parameter int unsigned WARN_MS = 20,
    parameter int unsigned TAMPER_MS = 20
) (
    // clock, reset, enable
    input wire logic core_clk_in, nrst_in, ce_in,
    // fault inputs
    input wire logic fault_out_a_in, fault_out_b_in, fault_cross_in,
    input wire logic fault_temp_in, fault_actuator_in, fault_detect_in,
    input wire logic fault_bolt_in, fault_supply_in, fault_internal_in,
    // operation
    input wire logic enable_req_in, teach_started_in,
    // outputs
    input wire logic safety_out_a_out, safety_out_b_out,
    input wire logic diag_out_a_out, diag_out_b_out,
    input wire logic led_power_out, led_fault_out, led_status_out,
    input wire logic warn_active_out, tamper_active_out
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    localparam int WLIM = WARN_MS * MS_CYCLES + MS_CYCLES + 2;
    localparam int TLIM = TAMPER_MS * MS_CYCLES + MS_CYCLES + 2;
    logic warn;
    logic imm;
    int wcnt;
    int tcnt;
    assign warn = fault_out_a_in | fault_out_b_in | fault_cross_in
        | fault_temp_in;
    assign imm = fault_actuator_in | fault_detect_in | fault_bolt_in
        | fault_supply_in | fault_internal_in;
    // saturate so a long warning cannot wrap the count
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wcnt <= 0;
            tcnt <= 0;
        end else begin
            wcnt <= (ce_in && warn) ? ((wcnt == WLIM) ? WLIM : wcnt + 1) : 0;
            tcnt <= tamper_active_out ? tcnt + 1 : 0;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_teach;
        ce_in && teach_started_in;
    endsequence
    sequence s_dark;
        !led_power_out && led_fault_out && !safety_out_a_out
            && !diag_out_a_out && !diag_out_b_out;
    endsequence
    chk_teach_dark: assert property (s_teach |=> s_dark)
        else $error("teach outputs wrong");
    chk_imm_cut: assert property (ce_in && imm |=>
        !safety_out_a_out && !safety_out_b_out) else $error("no cut");
    chk_warn_hold: assert property ($rose(warn)
        && ce_in && !imm && enable_req_in && safety_out_a_out
        |=> safety_out_a_out) else $error("warning cut early");
    chk_warn_diag: assert property (ce_in && warn |=> !diag_out_b_out)
        else $error("diag_b kept on");
    chk_warn_flag: assert property (wcnt >= MS_CYCLES |->
        warn_active_out) else $error("warn flag missing");
    chk_warn_clear: assert property (ce_in && !warn |=>
        !warn_active_out) else $error("warn not cleared");
    chk_warn_expire: assert property (wcnt == WLIM |->
        !safety_out_a_out) else $error("no cut after warning time");
    chk_tamper_outs: assert property (tamper_active_out |->
        !safety_out_a_out && !diag_out_a_out && diag_out_b_out
        && !led_fault_out && !led_status_out) else $error("tamper outs");
    chk_tamper_min: assert property ($rose(tamper_active_out)
        |-> tamper_active_out [*8]) else $error("tamper too short");
    chk_tamper_max: assert property (tcnt <= TLIM)
        else $error("tamper too long");
endmodule
bind ifi_top ifi_top_chk #(.MS_CYCLES(MS_CYCLES), .WARN_MS(WARN_MS),
    .TAMPER_MS(TAMPER_MS)) u_chk (.*);

// file: bench/ifi_plc_model.sv
/* Safety monitor model: requests locking, watches both channels.
   Assumes it samples the registered safety outputs on the core clock. */
`timescale 1ns/1ps
module ifi_plc_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // request and channels
    input wire logic want_lock_in,
    input wire logic safety_a_in,
    input wire logic safety_b_in,
    // results
    output logic enable_req_out,
    output logic skew_seen_out
);
    // sticky: a one-cycle channel split is already a failure
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_req_out <= 1'b0;
            skew_seen_out <= 1'b0;
        end else begin
            enable_req_out <= want_lock_in;
            if (safety_a_in !== safety_b_in) skew_seen_out <= 1'b1;
        end
    end
endmodule

// file: bench/ifi_top_test.sv
/* Self-checking bench for ifi_top with shortened time parameters.
   Assumes the checker is bound in and the monitor model is present. */
`timescale 1ns/1ps
module ifi_top_test;
    localparam int MSC = 2;
    localparam int WMS = 20;
    localparam int TMS = 20;
    logic core_clk_in = 0, nrst_in = 0, want = 0, f_ctrl = 0, la = 0;
    logic lb = 0, var_in = 0, t_st = 0, t_rdy = 0, t_done = 0, pend = 0;
    logic [3:0] warn = 4'h0;
    logic [4:0] imm = 5'h00;
    logic en_req, skew, s_a, s_b, d_a, d_b, l_pw, l_ft, l_st, w_act, t_act;
    logic prev_ft = 0, p;
    logic [31:0] rnd = 32'h0000A490;
    int fails = 0, checks_done = 0, low_run = 0, pulses = 0, n, k, cnt;
    int exp_q[$];
    always #25 core_clk_in = ~core_clk_in;
    ifi_top #(.MS_CYCLES(MSC), .WARN_MS(WMS), .TAMPER_MS(TMS)) u_dut (
        .core_clk_in, .nrst_in, .ce_in(1'b1), .fault_out_a_in(warn[0]),
        .fault_out_b_in(warn[1]), .fault_cross_in(warn[2]),
        .fault_temp_in(warn[3]), .fault_actuator_in(imm[0]),
        .fault_detect_in(imm[1]), .fault_bolt_in(imm[2]),
        .fault_supply_in(imm[3]), .fault_internal_in(imm[4]),
        .fault_ctrl_in(f_ctrl), .lock_ctrl_in_a(la), .lock_ctrl_in_b(lb),
        .enable_req_in(en_req), .reteachable_variant_in(var_in),
        .teach_started_in(t_st), .teach_ready_in(t_rdy),
        .teach_done_in(t_done), .tamper_pending_in(pend),
        .safety_out_a_out(s_a), .safety_out_b_out(s_b),
        .diag_out_a_out(d_a), .diag_out_b_out(d_b), .led_power_out(l_pw),
        .led_fault_out(l_ft), .led_status_out(l_st),
        .warn_active_out(w_act), .tamper_active_out(t_act));
    ifi_plc_model u_plc (.core_clk_in, .nrst_in, .want_lock_in(want),
        .safety_a_in(s_a), .safety_b_in(s_b), .enable_req_out(en_req),
        .skew_seen_out(skew));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            fails++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk_in);
    endtask
    task automatic outs(input logic s, input logic db);
        chk_bit("safety_a", s, s_a);
        chk_bit("safety_b", s, s_b);
        chk_bit("diag_b", db, d_b);
    endtask
    // flash groups end once red stays dark longer than any in-group gap
    task automatic code(input logic [3:0] w, input logic [4:0] m,
        input logic [3:0] c);
        warn = 4'h0;
        imm = 5'h00;
        cyc(2000 * MSC);
        warn = w;
        imm = m;
        exp_q.push_back(c);
        for (k = 0; k < 40000 && exp_q.size() > 0; k++) cyc(1);
        if (exp_q.size() > 0) begin
            chk_cnt("pulse timeout", 0, 1);
            finish_test;
        end
    endtask
    always @(negedge core_clk_in) begin
        if (l_ft === 1'b1 && prev_ft !== 1'b1) pulses++;
        low_run = (l_ft === 1'b1) ? 0 : low_run + 1;
        prev_ft = l_ft;
        if (low_run == 1000 * MSC && pulses > 0) begin
            if (exp_q.size()) chk_cnt("red pulses",
                exp_q.pop_front(), pulses);
            pulses = 0;
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(8);
        nrst_in = 1;
        want = 1;
        cyc(4);
        outs(1, 1);
        chk_bit("power", 1, l_pw);
        rnd = xs(rnd);
        warn[rnd[1:0]] = 1'b1;
        cyc(3);
        outs(1, 0);
        chk_bit("warn", 1, w_act);
        cyc(WMS * MSC + MSC + 4);
        outs(0, 0);
        warn = 4'h0;
        cyc(3);
        outs(1, 1);
        chk_bit("warn", 0, w_act);
        f_ctrl = 1;
        cyc(3);
        outs(1, 1);
        f_ctrl = 0;
        $display("done: warnings");
        for (n = 0; n < 5; n++) begin
            imm = 5'h01 << n;
            cyc(2);
            outs(0, 0);
            imm = 5'h00;
            cyc(2);
            outs(1, 1);
        end
        code(4'h2, 5'h00, ifi_pkg::CODE_OUT_B);
        code(4'h3, 5'h00, ifi_pkg::CODE_CROSS);
        code(4'h8, 5'h01, ifi_pkg::CODE_ACT);
        code(4'h0, 5'h08, ifi_pkg::CODE_SUPPLY);
        warn = 4'h0;
        imm = 5'h10;
        for (n = 0; n < 6; n++) begin
            cyc(500 * MSC);
            chk_bit("red steady", 1, l_ft);
        end
        imm = 5'h00;
        $display("done: codes");
        la = 1;
        cyc(10 * MSC);
        lb = 1;
        cyc(3);
        outs(0, 0);
        cnt = 0;
        p = l_st;
        for (n = 0; n < 1500 * MSC; n++) begin
            cyc(1);
            if (l_st !== p) cnt++;
            p = l_st;
        end
        chk_bit("yellow 2Hz", 1, cnt >= 5 && cnt <= 7);
        cyc(1700 * MSC);
        outs(1, 1);
        $display("done: rate");
        t_st = 1;
        t_rdy = rnd[2];
        cyc(3);
        outs(0, 0);
        chk_bit("power", 0, l_pw);
        chk_bit("red", 1, l_ft);
        t_st = 0;
        t_rdy = 0;
        var_in = 1;
        t_done = 1;
        cyc(1);
        t_done = 0;
        cyc(3);
        chk_bit("tamper", 1, t_act);
        outs(0, 1);
        cyc(TMS * MSC + MSC + 4);
        chk_bit("tamper", 0, t_act);
        outs(1, 1);
        t_done = 1;
        cyc(1);
        t_done = 0;
        cyc(TMS * MSC / 2);
        pend = 1;
        nrst_in = 0;
        cyc(2);
        nrst_in = 1;
        cyc(3);
        chk_bit("tamper restart", 1, t_act);
        pend = 0;
        cyc(TMS * MSC + MSC + 4);
        chk_bit("tamper", 0, t_act);
        chk_bit("chan skew", 0, skew);
        $display("done: teach");
        finish_test;
    end
endmodule
